// [core/ecs_pkg.sv]
// Constants and types shared by the expander channel scan sequencer.
package ecs_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int DEV_CH_W = 4;
    localparam int SUB_CH_W = 6;
    localparam int UNIT_W = 2;
    localparam logic [DEV_CH_W-1:0] MAX_DEV_SE = 4'hf;
    localparam logic [DEV_CH_W-1:0] MAX_DEV_DIFF = 4'h7;
    localparam logic [SUB_CH_W-1:0] MAX_SUB_SE = 6'h3f;
    localparam logic [SUB_CH_W-1:0] MAX_SUB_DIFF = 6'h1f;
    localparam logic [1:0] SUB_PER_GROUP_M1 = 2'h3;
    // ------------------------------------------------------------------
    // Unit count encodings (0, 1, 2 or 4 units)
    // ------------------------------------------------------------------
    localparam logic [2:0] UNITS_NONE = 3'h0;
    localparam logic [2:0] UNITS_ONE = 3'h1;
    localparam logic [2:0] UNITS_TWO = 3'h2;
    localparam logic [2:0] UNITS_FOUR = 3'h4;
    // ------------------------------------------------------------------
    // Scan modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ECS_MODE_LIST = 2'h0,
        ECS_MODE_RANGE = 2'h1,
        ECS_MODE_SINGLE = 2'h2
    } ecs_mode_t;
    typedef enum logic [1:0] {
        ECS_IDLE = 2'b00,
        ECS_RUN = 2'b01,
        ECS_LAST = 2'b11
    } ecs_state_t;
endpackage : ecs_pkg

// [core/ecs_scan_seq.sv]
// Scan sequencer that expands a channel list through external multiplexer units.
//
// Summary of operation
// - Unit count is 0, 1, 2 or 4, fixed before a scan starts.
// - One, two or four units give 4, 8 or 16 subchannels per entry.
// - With no units an entry selects its device channel, 0-15 or 0-7.
// - Each unit offers subchannels 0-63 single-ended or 0-31 differential.
// - Entry k selects subchannels 4k to 4k+3 on every attached unit.
// - Subchannels within a unit go in fixed ascending order.
// - With two units, unit 1's group goes before unit 2's group.
// - With four units, groups go in unit order 1, 2, 3, 4.
// - Entries are taken in list order, each fully expanded first.
// - Counters step device and expander multiplexers automatically.
// - Single specifier picks subchannel x on unit y, alone in the list.
// - Range specifier returns all subchannels of device channels x to y.
`timescale 1ns/1ps
module ecs_scan_seq #(
    parameter int LIST_DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] cfg_units,
    input wire logic cfg_diff,
    input wire ecs_pkg::ecs_mode_t cfg_mode,
    input wire logic [ecs_pkg::DEV_CH_W-1:0] range_first,
    input wire logic [ecs_pkg::DEV_CH_W-1:0] range_last,
    input wire logic [1:0] single_unit,
    input wire logic [ecs_pkg::SUB_CH_W-1:0] single_sub,
    input wire logic list_wr,
    input wire logic [$clog2(LIST_DEPTH)-1:0] list_wr_addr,
    input wire logic [ecs_pkg::DEV_CH_W-1:0] list_wr_data,
    input wire logic [$clog2(LIST_DEPTH+1)-1:0] list_len,
    input wire logic start,
    input wire logic stop,
    input wire logic conv_done,
    output logic busy,
    output logic cfg_error,
    output logic [ecs_pkg::DEV_CH_W-1:0] dev_mux_ch,
    output logic [ecs_pkg::UNIT_W-1:0] exp_unit,
    output logic [ecs_pkg::SUB_CH_W-1:0] exp_sub_ch,
    output logic exp_enable,
    output logic scan_done
);
    localparam int AW = $clog2(LIST_DEPTH);
    localparam int LW = $clog2(LIST_DEPTH+1);

    // ------------------------------------------------------------------
    // State and list storage
    // ------------------------------------------------------------------
    typedef struct packed {
        ecs_pkg::ecs_state_t state;
        ecs_pkg::ecs_mode_t mode;
        logic [2:0] units;
        logic diff;
        logic [AW-1:0] ptr;
        logic [ecs_pkg::DEV_CH_W-1:0] dev_ch;
        logic [ecs_pkg::DEV_CH_W-1:0] last_ch;
        logic [1:0] sub_idx;
        logic [1:0] unit;
        logic err;
        logic done;
        logic [ecs_pkg::DEV_CH_W-1:0] out_mux;
        logic [ecs_pkg::UNIT_W-1:0] out_unit;
        logic [ecs_pkg::SUB_CH_W-1:0] out_sub;
        logic out_en;
    } ecs_regs_t;

    ecs_regs_t r;
    ecs_regs_t next_r;
    logic [ecs_pkg::DEV_CH_W-1:0] list_mem [LIST_DEPTH];

    ecs_sel_if sel ();

    ecs_sel_decode u_dec (
        .sel(sel.dec)
    );

    // Writes to the scan list are refused while a scan runs.
    always_ff @(posedge ref_clk) begin
        if (list_wr && r.state == ecs_pkg::ECS_IDLE) begin
            list_mem[list_wr_addr] <= list_wr_data;
        end
    end

    // Last unit index for a unit count, or zero for no expanders.
    function automatic logic [1:0] last_unit(input logic [2:0] n);
        unique case (n)
            ecs_pkg::UNITS_TWO: last_unit = 2'h1;
            ecs_pkg::UNITS_FOUR: last_unit = 2'h3;
            default: last_unit = 2'h0;
        endcase
    endfunction : last_unit

    // Unit count legality; other codes are refused at start.
    function automatic logic units_ok(input logic [2:0] n);
        units_ok = (n == ecs_pkg::UNITS_NONE) || (n == ecs_pkg::UNITS_ONE) ||
                   (n == ecs_pkg::UNITS_TWO) || (n == ecs_pkg::UNITS_FOUR);
    endfunction : units_ok

    // Highest legal device channel for the input configuration.
    function automatic logic [ecs_pkg::DEV_CH_W-1:0] max_dev(input logic d, input logic [2:0] n);
        if (n == ecs_pkg::UNITS_NONE) begin
            max_dev = d ? ecs_pkg::MAX_DEV_DIFF : ecs_pkg::MAX_DEV_SE;
        end else begin
            max_dev = d ? ecs_pkg::MAX_SUB_DIFF[5:2] : ecs_pkg::MAX_SUB_SE[5:2];
        end
    endfunction : max_dev

    // Selection handed to the decoder.
    assign sel.dev_ch = r.dev_ch;
    assign sel.sub_idx = r.sub_idx;
    assign sel.unit = r.unit;
    assign sel.expanded = (r.units != ecs_pkg::UNITS_NONE);

    logic end_group;
    logic end_entry;
    logic [ecs_pkg::DEV_CH_W-1:0] start_ch;
    logic start_bad;

    // Position flags and start checks.
    always_comb begin
        end_group = (r.sub_idx == ecs_pkg::SUB_PER_GROUP_M1) || !sel.expanded ||
                    (r.mode == ecs_pkg::ECS_MODE_SINGLE);
        end_entry = end_group && ((r.unit == last_unit(r.units)) ||
                    (r.mode == ecs_pkg::ECS_MODE_SINGLE));
        start_ch = (cfg_mode == ecs_pkg::ECS_MODE_RANGE) ? range_first : list_mem[0];
        start_bad = !units_ok(cfg_units);
        unique case (cfg_mode)
            ecs_pkg::ECS_MODE_SINGLE: begin
                start_bad = start_bad || cfg_units == ecs_pkg::UNITS_NONE ||
                    single_unit > last_unit(cfg_units) ||
                    single_sub > (cfg_diff ? ecs_pkg::MAX_SUB_DIFF : ecs_pkg::MAX_SUB_SE);
            end
            ecs_pkg::ECS_MODE_RANGE: begin
                start_bad = start_bad || range_first > range_last ||
                    range_last > max_dev(cfg_diff, cfg_units);
            end
            default: begin
                start_bad = start_bad || list_len == '0 || start_ch > max_dev(cfg_diff, cfg_units);
            end
        endcase
    end

    // Next-state logic of the whole sequencer.
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.out_mux = sel.mux_ch;
        next_r.out_sub = (r.mode == ecs_pkg::ECS_MODE_SINGLE) ? single_sub : sel.sub_ch;
        next_r.out_unit = r.unit;
        next_r.out_en = sel.expanded && r.state != ecs_pkg::ECS_IDLE;
        unique case (r.state)
            ecs_pkg::ECS_IDLE: begin
                if (start) begin
                    next_r.err = start_bad;
                    if (!start_bad) begin
                        next_r.units = cfg_units;
                        next_r.diff = cfg_diff;
                        next_r.mode = cfg_mode;
                        next_r.ptr = '0;
                        next_r.sub_idx = '0;
                        next_r.dev_ch = (cfg_mode == ecs_pkg::ECS_MODE_SINGLE) ?
                            single_sub[5:2] : start_ch;
                        next_r.unit = (cfg_mode == ecs_pkg::ECS_MODE_SINGLE) ? single_unit : 2'h0;
                        next_r.last_ch = range_last;
                        next_r.state = ecs_pkg::ECS_RUN;
                    end
                end
            end
            ecs_pkg::ECS_RUN, ecs_pkg::ECS_LAST: begin
                if (stop) begin
                    next_r.state = ecs_pkg::ECS_IDLE;
                end else if (conv_done) begin
                    if (!end_group) begin
                        next_r.sub_idx = r.sub_idx + 2'h1;
                    end else if (!end_entry) begin
                        next_r.sub_idx = '0;
                        next_r.unit = r.unit + 2'h1;
                    end else begin
                        next_r.sub_idx = '0;
                        next_r.unit = '0;
                        unique case (r.mode)
                            ecs_pkg::ECS_MODE_SINGLE: begin
                                // A single channel keeps its unit on every pass.
                                next_r.done = 1'b1;
                                next_r.unit = r.unit;
                            end
                            ecs_pkg::ECS_MODE_RANGE: begin
                                next_r.done = (r.dev_ch == r.last_ch);
                                next_r.dev_ch = next_r.done ? range_first : r.dev_ch + 4'h1;
                            end
                            default: begin
                                next_r.done = ({1'b0, r.ptr} == LW'(list_len - 1'b1));
                                next_r.ptr = next_r.done ? '0 : r.ptr + 1'b1;
                                next_r.dev_ch = list_mem[next_r.ptr];
                            end
                        endcase
                    end
                    next_r.state = next_r.done ? ecs_pkg::ECS_LAST : ecs_pkg::ECS_RUN;
                end
            end
            default: next_r.state = ecs_pkg::ECS_IDLE;
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Scans repeat until stopped; each pass ends with one scan_done pulse.
    assign busy = (r.state != ecs_pkg::ECS_IDLE);
    assign cfg_error = r.err;
    assign dev_mux_ch = r.out_mux;
    assign exp_unit = r.out_unit;
    assign exp_sub_ch = r.out_sub;
    assign exp_enable = r.out_en;
    assign scan_done = r.done;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence group_end_s;
        conv_done && busy && r.sub_idx == 2'h3 && !stop;
    endsequence

    sub_ascend_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (busy && conv_done && !stop && sel.expanded && r.mode != ecs_pkg::ECS_MODE_SINGLE
         && r.sub_idx != 2'h3) |=> (r.sub_idx == $past(r.sub_idx) + 2'h1))
        else $error("Subchannel did not step up by one.");
    unit_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (group_end_s ##0 (r.unit != last_unit(r.units)
         && r.mode != ecs_pkg::ECS_MODE_SINGLE)) |=> (r.unit == $past(r.unit) + 2'h1))
        else $error("Unit order broken.");
    sub_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (busy && r.mode != ecs_pkg::ECS_MODE_SINGLE) |=> (exp_sub_ch[5:2] == $past(r.dev_ch)))
        else $error("Subchannel not in entry group.");
    unit_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        busy |-> (r.unit <= last_unit(r.units)))
        else $error("Unit beyond attached count.");
    units_legal_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        busy |-> units_ok(r.units))
        else $error("Illegal unit count in use.");
    bad_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!busy && start && start_bad) |=> (!busy && cfg_error))
        else $error("Bad configuration accepted.");
    sub_limit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (busy && r.diff && r.mode != ecs_pkg::ECS_MODE_SINGLE) |-> r.dev_ch <= 4'h7)
        else $error("Differential subchannel out of range.");
    range_end_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        scan_done && $past(r.mode) == ecs_pkg::ECS_MODE_RANGE |-> $past(r.dev_ch) == r.last_ch)
        else $error("Range ended early.");
    wrap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (group_end_s ##0 (r.unit == last_unit(r.units) && sel.expanded))
        |=> (r.sub_idx == 2'h0 && r.unit == 2'h0))
        else $error("No wrap after last group.");
endmodule : ecs_scan_seq

// [core/ecs_sel_decode.sv]
// Decoder from scan position to expander subchannel and device multiplexer channel.
`timescale 1ns/1ps
module ecs_sel_decode (
    ecs_sel_if.dec sel
);
    // ------------------------------------------------------------------
    // Subchannel decode
    // ------------------------------------------------------------------
    // Entry k maps to subchannel 4k plus the position within the group.
    assign sel.sub_ch = {sel.dev_ch, sel.sub_idx};
    // Without expanders the entry picks its own device channel; with them the
    // device multiplexer follows the entry too, since units share that input.
    assign sel.mux_ch = sel.dev_ch;
endmodule : ecs_sel_decode

// [core/ecs_sel_if.sv]
// Interface carrying the current selection between the sequencer and its decoder.
`timescale 1ns/1ps
interface ecs_sel_if;
    logic [ecs_pkg::DEV_CH_W-1:0] dev_ch;
    logic [1:0] sub_idx;
    logic [ecs_pkg::UNIT_W-1:0] unit;
    logic expanded;
    logic [ecs_pkg::SUB_CH_W-1:0] sub_ch;
    logic [ecs_pkg::DEV_CH_W-1:0] mux_ch;
    modport seq (output dev_ch, output sub_idx, output unit, output expanded,
                 input sub_ch, input mux_ch);
    modport dec (input dev_ch, input sub_idx, input unit, input expanded,
                 output sub_ch, output mux_ch);
endinterface : ecs_sel_if

// [tb/ecs_conv_model.sv]
// Behavioural converter and expander boards that pace the scan.
`timescale 1ns/1ps
module ecs_conv_model (
    input wire logic ref_clk,
    input wire logic busy,
    input wire logic [ecs_pkg::DEV_CH_W-1:0] dev_mux_ch,
    input wire logic [ecs_pkg::UNIT_W-1:0] exp_unit,
    input wire logic [ecs_pkg::SUB_CH_W-1:0] exp_sub_ch,
    input wire logic exp_enable,
    input wire logic [3:0] gap,
    output logic conv_done
);
    logic [12:0] seen [$];
    int cnt = 0;
    initial conv_done = 1'b0;
    // Each conversion records the selection it measured, then steps the scan.
    // After busy rises the count starts one cycle late, because the selection
    // outputs trail the internal position by one clock.
    always @(negedge ref_clk) begin
        if (busy !== 1'b1) begin
            conv_done <= 1'b0;
            cnt = -1;
        end else if (conv_done) begin
            conv_done <= 1'b0;
            cnt = 0;
        end else if (cnt >= int'(gap)) begin
            seen.push_back({exp_enable, exp_unit, exp_sub_ch, dev_mux_ch});
            conv_done <= 1'b1;
        end else begin
            cnt++;
        end
    end
endmodule : ecs_conv_model

// [tb/tb.sv]
// Self-checking testbench for the expander channel scan sequencer.
`timescale 1ns/1ps
module tb;
    logic ref_clk, sys_rst, cfg_diff, list_wr, start, stop, conv_done;
    logic busy, cfg_error, exp_enable, scan_done;
    logic [2:0] cfg_units;
    ecs_pkg::ecs_mode_t cfg_mode;
    logic [3:0] range_first, range_last, list_wr_addr, list_wr_data, dev_mux_ch, gap;
    logic [1:0] single_unit, exp_unit;
    logic [5:0] single_sub, exp_sub_ch;
    logic [4:0] list_len;
    logic [3:0] ent [16];
    int error_cnt = 0;
    int tests_run = 0;
    int done_cnt = 0;

    ecs_scan_seq #(.LIST_DEPTH(16)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cfg_units(cfg_units), .cfg_diff(cfg_diff), .cfg_mode(cfg_mode),
        .range_first(range_first), .range_last(range_last), .single_unit(single_unit),
        .single_sub(single_sub), .list_wr(list_wr), .list_wr_addr(list_wr_addr),
        .list_wr_data(list_wr_data), .list_len(list_len), .start(start), .stop(stop),
        .conv_done(conv_done), .busy(busy), .cfg_error(cfg_error),
        .dev_mux_ch(dev_mux_ch), .exp_unit(exp_unit), .exp_sub_ch(exp_sub_ch),
        .exp_enable(exp_enable), .scan_done(scan_done));
    ecs_conv_model conv_model (.ref_clk(ref_clk), .busy(busy), .dev_mux_ch(dev_mux_ch),
        .exp_unit(exp_unit), .exp_sub_ch(exp_sub_ch), .exp_enable(exp_enable),
        .gap(gap), .conv_done(conv_done));

    // The clock toggles every 5 ns for a 100 MHz rate.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Pass-end pulses are counted so each scan can check its wrap.
    always @(negedge ref_clk) begin
        if (scan_done === 1'b1) done_cnt++;
    end
    // The watchdog ends a hung run as a failure.
    initial begin
        #200000;
        error_cnt++;
        $display("ERROR at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
        test_done();
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic load_list(input int nent);
        for (int i = 0; i < nent; i++) begin
            @(negedge ref_clk);
            list_wr = 1'b1;
            list_wr_addr = 4'(i);
            list_wr_data = ent[i];
        end
        @(negedge ref_clk) list_wr = 1'b0;
        list_len = 5'(nent);
    endtask : load_list

    // Starts a scan, lets the converter take nsamp samples, then stops it.
    task automatic go(input ecs_pkg::ecs_mode_t mode, input logic [2:0] units, input int nsamp);
        int t;
        @(negedge ref_clk);
        cfg_mode = mode;
        cfg_units = units;
        conv_model.seen.delete();
        done_cnt = 0;
        start = 1'b1;
        @(negedge ref_clk) start = 1'b0;
        t = 0;
        while (conv_model.seen.size() < nsamp && t < 3000) begin
            @(negedge ref_clk);
            t++;
        end
        stop = 1'b1;
        @(negedge ref_clk) stop = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : go

    // One full pass plus the first step of the next, against the table order.
    task automatic run_scan(input ecs_pkg::ecs_mode_t mode, input logic [2:0] units,
                            input int nent, input string name);
        int spe, n, e, r;
        logic [12:0] exp, got, mask;
        spe = (units == 3'h0) ? 1 : 4 * int'(units);
        n = nent * spe;
        go(mode, units, n + 1);
        mask = (units == 3'h0) ? 13'h100f : 13'h1fff;
        for (int i = 0; i <= n; i++) begin
            e = ent[(i % n) / spe];
            r = (i % n) % spe;
            exp = {units != 3'h0, 2'(r / 4), 6'(4 * e + r % 4), 4'(e)};
            got = (i < conv_model.seen.size()) ? conv_model.seen[i] : 13'bx;
            check(got & mask, exp & mask);
        end
        check(13'(done_cnt), 13'h1);
        check({12'h0, busy}, 13'h0);
        $display("test %s done", name);
    endtask : run_scan

    task automatic refused(input logic [2:0] units, input logic [1:0] unit_idx);
        @(negedge ref_clk);
        cfg_mode = ecs_pkg::ECS_MODE_SINGLE;
        cfg_units = units;
        single_unit = unit_idx;
        start = 1'b1;
        @(negedge ref_clk) start = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({11'h0, cfg_error, busy}, 13'h002);
        $display("test refused single start done");
    endtask : refused

    task automatic single_scan();
        single_unit = 2'h3;
        single_sub = 6'h08;
        go(ecs_pkg::ECS_MODE_SINGLE, ecs_pkg::UNITS_FOUR, 4);
        check({12'h0, cfg_error}, 13'h0);
        for (int i = 0; i < 4; i++) begin
            check(conv_model.seen[i] & 13'h1ff0, 13'h1c80);
        end
        $display("test single channel done");
    endtask : single_scan

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {cfg_units, cfg_diff, list_wr, start, stop, list_len} = '0;
        {range_first, range_last, list_wr_addr, list_wr_data, single_unit, single_sub} = '0;
        cfg_mode = ecs_pkg::ECS_MODE_LIST;
        gap = 4'h0;
        repeat (4) @(negedge ref_clk);
        check({exp_enable, exp_unit, exp_sub_ch, dev_mux_ch}, 13'h0);
        check({10'h0, busy, cfg_error, scan_done}, 13'h0);
        sys_rst = 1'b0;
        ent = '{0: 4'hf, 1: 4'h0, 2: 4'h7, default: 4'h0};
        load_list(3);
        run_scan(ecs_pkg::ECS_MODE_LIST, ecs_pkg::UNITS_TWO, 3, "two units");
        gap = 4'h3;
        ent = '{0: 4'h3, 1: 4'h9, default: 4'h0};
        load_list(2);
        run_scan(ecs_pkg::ECS_MODE_LIST, ecs_pkg::UNITS_FOUR, 2, "four units");
        gap = 4'h5;
        ent = '{0: 4'h0, 1: 4'hf, default: 4'h0};
        load_list(2);
        run_scan(ecs_pkg::ECS_MODE_LIST, ecs_pkg::UNITS_ONE, 2, "one unit");
        gap = 4'h2;
        cfg_diff = 1'b1;
        ent = '{0: 4'h5, 1: 4'h7, 2: 4'h2, default: 4'h0};
        load_list(3);
        run_scan(ecs_pkg::ECS_MODE_LIST, ecs_pkg::UNITS_NONE, 3, "no units");
        cfg_diff = 1'b0;
        range_first = 4'he;
        range_last = 4'hf;
        ent = '{0: 4'he, 1: 4'hf, default: 4'h0};
        run_scan(ecs_pkg::ECS_MODE_RANGE, ecs_pkg::UNITS_ONE, 2, "range");
        refused(ecs_pkg::UNITS_NONE, 2'h0);
        refused(ecs_pkg::UNITS_TWO, 2'h2);
        single_scan();
        test_done();
    end
endmodule : tb
